// File: auf_host_model.sv
// Companion processor model on the application serial port
module auf_host_model
  import auf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       line_in,
  input  wire logic       hold,
  input  wire logic [7:0] send_data,
  input  wire logic       send,
  input  wire logic       grant_in_n,
  output logic            grant_n,
  output logic            line_out,
  output logic            in_request_n,
  output logic            got,
  output logic [7:0]      got_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Busy companion raises the grant, even mid-packet
  assign grant_n = hold;

  initial begin
    got = 1'b0;
    forever begin
      @(negedge line_in);
      repeat (API_BIT_CYC * 3 / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        got_data[i] = line_in;
        repeat (API_BIT_CYC) @(posedge clk);
      end
      got = 1'b1;
      @(posedge clk);
      got = 1'b0;
    end
  end

  initial begin
    line_out = LINE_IDLE;
    in_request_n = REQ_IDLE;
    forever begin
      logic [9:0] frame;
      @(posedge send);
      frame = {1'b1, send_data, 1'b0};
      in_request_n = 1'b0;
      for (int w = 0; w < 50 && grant_in_n !== 1'b0; w++) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
        line_out = frame[i];
        repeat (API_BIT_CYC) @(negedge clk);
      end
      in_request_n = 1'b1;
      repeat (IN_GAP_CYC) @(negedge clk);
    end
  end
endmodule : auf_host_model

// File: auf_pkg.sv
// Package for the host-port UART block: timing constants and carrier types
package auf_pkg;

  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned API_BAUD       = 115_200;
  localparam int unsigned CLI_BAUD       = 9_600;
  // Cycles per bit, rounded down to the nearest whole cycle
  localparam int unsigned API_BIT_CYC    = CLK_HZ / API_BAUD;
  localparam int unsigned CLI_BIT_CYC    = CLK_HZ / CLI_BAUD;
  // Gap times are given directly in clock cycles
  localparam int unsigned OUT_GAP_CYC    = 1000;
  localparam int unsigned IN_GAP_CYC     = 1000;
  localparam int unsigned IN_IDLE_CYC    = 2 * API_BIT_CYC * 10;
  localparam int unsigned CNT_W          = 16;
  localparam logic        REQ_IDLE       = 1'b1;
  localparam logic        LINE_IDLE      = 1'b1;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } auf_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
  } auf_rx_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_REQ  = 2'b01,
    TX_SEND = 2'b10,
    TX_GAP  = 2'b11
  } auf_txst_t;

endpackage : auf_pkg

// File: auf_top.sv
// Host-port UART block: packet transmitter with level flow control, receiver, command-line UART
// What this block does
// - The outbound channel uses level flow control, the inbound channel needs none, and it runs at 115200 baud.
// - Every character is one start bit, eight data bits, one stop bit and no parity; packets are framed above.
// - Each outbound packet begins with the outbound request driven low before any data moves.
// - Once the grant is seen low the whole packet goes out without checking the grant again.
// - After the last byte the request goes high and stays high for at least the outbound gap time.
// - If the grant is still low after the gap and another packet waits, it goes out straight away.
// - Both ports watch their inputs all the time, wake for a transfer and go back to idle after it.
// - The command-line port has only data lines, runs at 9600 baud, one stop bit, no parity, no flow control.
// - Inbound request and grant are optional; unused, the request sits high and the grant is ignored.
module auf_top
  import auf_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  // Outbound packet stream from the node logic
  input  wire auf_byte_t tx_byte,
  input  wire logic      tx_valid,
  output logic           tx_ready,
  // Inbound bytes to the node logic
  output auf_rx_t        rx_byte,
  output logic           rx_valid,
  input  wire logic      rx_accept_ok,
  output logic           api_busy,
  // Application serial pins
  output logic           api_serial_out,
  input  wire logic      api_serial_in,
  output logic           outbound_request_n,
  input  wire logic      outbound_grant_n,
  input  wire logic      inbound_request_n,
  output logic           inbound_grant_n,
  // Command-line port
  input  wire logic [7:0] cli_tx_data,
  input  wire logic      cli_tx_valid,
  output logic           cli_tx_ready,
  output logic           cli_serial_out,
  input  wire logic      cli_serial_in,
  output auf_rx_t        cli_rx_byte,
  output logic           cli_rx_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared character shifters, one per direction per port

  logic       api_tx_go;
  logic       api_tx_busy;
  logic       cli_tx_busy;
  logic [7:0] api_tx_data_q;

  auf_tx_ser #(.BIT_CYC(API_BIT_CYC)) u_api_tx (
    .clk    (clk),
    .resetn (resetn),
    .go     (api_tx_go),
    .data   (api_tx_data_q),
    .busy   (api_tx_busy),
    .line   (api_serial_out)
  );

  auf_rx_des #(.BIT_CYC(API_BIT_CYC)) u_api_rx (
    .clk    (clk),
    .resetn (resetn),
    .line   (api_serial_in),
    .rx     (rx_byte),
    .valid  (rx_valid)
  );

  auf_tx_ser #(.BIT_CYC(CLI_BIT_CYC)) u_cli_tx (
    .clk    (clk),
    .resetn (resetn),
    .go     (cli_tx_valid && cli_tx_ready),
    .data   (cli_tx_data),
    .busy   (cli_tx_busy),
    .line   (cli_serial_out)
  );

  auf_rx_des #(.BIT_CYC(CLI_BIT_CYC)) u_cli_rx (
    .clk    (clk),
    .resetn (resetn),
    .line   (cli_serial_in),
    .rx     (cli_rx_byte),
    .valid  (cli_rx_valid)
  );

  assign cli_tx_ready = !cli_tx_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Outbound packet sequencer

  auf_txst_t        st_q;
  logic [CNT_W-1:0] gap_q;
  logic             last_q;
  logic             have_q;

  // Byte accepted only while a packet is granted, the holding register is empty and the last byte is not yet taken
  assign tx_ready  = (st_q == TX_SEND) && !have_q && !last_q;
  assign api_tx_go = have_q && !api_tx_busy;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q               <= TX_IDLE;
      gap_q              <= '0;
      last_q             <= 1'b0;
      have_q             <= 1'b0;
      api_tx_data_q      <= 8'h00;
      outbound_request_n <= REQ_IDLE;
    end else begin
      if (api_tx_go) begin
        have_q <= 1'b0;
      end
      unique case (st_q)
        TX_IDLE: begin
          if (tx_valid) begin
            outbound_request_n <= 1'b0;
            st_q               <= TX_REQ;
          end
        end
        TX_REQ: begin
          // Tied-low grant passes straight through
          if (!outbound_grant_n) begin
            st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          // Grant no longer looked at here
          if (tx_valid && tx_ready) begin
            api_tx_data_q <= tx_byte.data;
            have_q        <= 1'b1;
            last_q        <= tx_byte.last;
          end else if (last_q && !have_q && !api_tx_busy && !api_tx_go) begin
            outbound_request_n <= REQ_IDLE;
            last_q             <= 1'b0;
            gap_q              <= CNT_W'(OUT_GAP_CYC);
            st_q               <= TX_GAP;
          end
        end
        TX_GAP: begin
          if (gap_q > CNT_W'(1)) begin
            gap_q <= gap_q - CNT_W'(1);
          end else if (tx_valid) begin
            // Next packet re-requests; a still-low grant sends at once
            outbound_request_n <= 1'b0;
            st_q               <= TX_REQ;
          end else begin
            st_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inbound optional flow control

  logic             in_act_q;
  logic [CNT_W-1:0] idle_q;

  // Unused request stays high so the grant stays high and is ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inbound_grant_n <= REQ_IDLE;
      in_act_q        <= 1'b0;
      idle_q          <= '0;
    end else begin
      if (!in_act_q) begin
        if (!inbound_request_n && rx_accept_ok) begin
          inbound_grant_n <= 1'b0;
          in_act_q        <= 1'b1;
          idle_q          <= '0;
        end
      end else begin
        // Packet over once the line idles long or request drops away
        if (!api_serial_in || rx_valid) begin
          idle_q <= '0;
        end else if (idle_q != CNT_W'(IN_IDLE_CYC)) begin
          idle_q <= idle_q + CNT_W'(1);
        end
        if (inbound_request_n || idle_q == CNT_W'(IN_IDLE_CYC)) begin
          inbound_grant_n <= REQ_IDLE;
          in_act_q        <= inbound_request_n ? 1'b0 : in_act_q;
        end
      end
    end
  end

  assign api_busy = (st_q != TX_IDLE) || in_act_q || api_tx_busy;

endmodule : auf_top

////////////////////////////////////////////////////////////////////////////
// Character transmitter, 8N1

module auf_tx_ser
  import auf_pkg::*;
#(
  parameter int unsigned BIT_CYC = 434
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            line
);
  logic [CNT_W-1:0] cnt_q;
  logic [3:0]       bit_q;
  logic [9:0]       sh_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy  <= 1'b0;
      line  <= LINE_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q  <= 10'h3FF;
    end else if (!busy) begin
      if (go) begin
        busy  <= 1'b1;
        line  <= 1'b0;
        sh_q  <= {1'b1, 1'b1, data};
        cnt_q <= CNT_W'(BIT_CYC - 1);
        bit_q <= 4'h0;
      end
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end else if (bit_q == 4'h9) begin
      busy <= 1'b0;
    end else begin
      line  <= sh_q[0];
      sh_q  <= {1'b1, sh_q[9:1]};
      bit_q <= bit_q + 4'h1;
      cnt_q <= CNT_W'(BIT_CYC - 1);
    end
  end
endmodule : auf_tx_ser

////////////////////////////////////////////////////////////////////////////
// Character receiver, 8N1, mid-bit sampling

module auf_rx_des
  import auf_pkg::*;
#(
  parameter int unsigned BIT_CYC = 434
) (
  input  wire logic    clk,
  input  wire logic    resetn,
  input  wire logic    line,
  output auf_rx_t      rx,
  output logic         valid
);
  logic             act_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0]       bit_q;
  logic [7:0]       sh_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_q <= 1'b0;
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      rx    <= '0;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!act_q) begin
        if (!line) begin
          act_q <= 1'b1;
          cnt_q <= CNT_W'(BIT_CYC / 2);
          bit_q <= 4'h0;
        end
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end else begin
        cnt_q <= CNT_W'(BIT_CYC - 1);
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'h0 && line) begin
          act_q <= 1'b0; // False start glitch
        end else if (bit_q >= 4'h1 && bit_q <= 4'h8) begin
          sh_q <= {line, sh_q[7:1]};
        end else if (bit_q == 4'h9) begin
          rx    <= '{data: sh_q, frame_err: !line};
          valid <= 1'b1;
          act_q <= 1'b0;
        end
      end
    end
  end
endmodule : auf_rx_des

// File: auf_top_properties.sv
// Port-level assertions for the host-port UART block
module auf_top_chk
  import auf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic cli_rx_valid,
  input wire logic api_serial_out,
  input wire logic outbound_request_n,
  input wire logic outbound_grant_n,
  input wire logic inbound_request_n,
  input wire logic inbound_grant_n,
  input wire logic rx_accept_ok,
  input wire logic cli_tx_valid,
  input wire logic cli_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CNT_W-1:0] gap_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Saturating count of request-high cycles; starts full so the first request is free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) gap_q <= CNT_W'(OUT_GAP_CYC);
    else if (!outbound_request_n) gap_q <= '0;
    else if (gap_q < CNT_W'(OUT_GAP_CYC)) gap_q <= gap_q + CNT_W'(1);
  end

  line_idle_a: assert property (outbound_request_n |-> api_serial_out)
    else $error("data without request");
  gap_hold_a: assert property ($fell(outbound_request_n) |-> gap_q >= CNT_W'(OUT_GAP_CYC - 1))
    else $error("packet gap too short");
  grant_go_a: assert property ($fell(outbound_request_n) && !outbound_grant_n && tx_valid |-> ##[0:3] tx_ready)
    else $error("granted packet not started");
  ready_req_a: assert property (tx_ready |-> !outbound_request_n)
    else $error("byte taken without request");
  start_len_a: assert property ($fell(api_serial_out) |=> !api_serial_out [*8])
    else $error("start bit too short");
  in_grant_a: assert property ($fell(inbound_request_n) && rx_accept_ok |=> !inbound_grant_n)
    else $error("inbound grant late");
  in_drop_a: assert property (inbound_request_n |=> inbound_grant_n)
    else $error("inbound grant without request");
  cli_busy_a: assert property (cli_tx_valid && cli_tx_ready |=> !cli_tx_ready [*8])
    else $error("command port ready while sending");

  back_c: cover property ($fell(outbound_request_n) && !outbound_grant_n && tx_valid);
  in_c: cover property (rx_valid);
  cli_c: cover property (cli_rx_valid);
endmodule : auf_top_chk

bind auf_top auf_top_chk auf_top_chk_inst (.*);

// File: tb_auf_top.sv
// Self-checking testbench for the host-port UART block
module tb_auf_top
  import auf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, tx_valid = 1'b0, rx_accept_ok = 1'b1, cli_tx_valid = 1'b0;
  logic hold = 1'b1, send = 1'b0;
  logic [7:0] cli_tx_data = 8'h00, send_data = 8'h00, lfsr = 8'h3F, got_data;
  auf_byte_t tx_byte = '0;
  auf_rx_t rx_byte, cli_rx_byte;
  logic tx_ready, rx_valid, api_serial_out, api_serial_in, outbound_request_n, outbound_grant_n;
  logic inbound_request_n, inbound_grant_n, cli_tx_ready, cli_serial_out, cli_rx_valid, got, api_busy;
  logic [7:0] exp_q[$];
  int fail_count = 0, n_tests = 0;

  // Command port looped back on itself
  auf_top auf_top_inst (.clk(clk), .resetn(resetn), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_accept_ok(rx_accept_ok), .api_busy(api_busy),
    .api_serial_out(api_serial_out), .api_serial_in(api_serial_in), .outbound_request_n(outbound_request_n),
    .outbound_grant_n(outbound_grant_n), .inbound_request_n(inbound_request_n), .inbound_grant_n(inbound_grant_n),
    .cli_tx_data(cli_tx_data), .cli_tx_valid(cli_tx_valid), .cli_tx_ready(cli_tx_ready),
    .cli_serial_out(cli_serial_out), .cli_serial_in(cli_serial_out), .cli_rx_byte(cli_rx_byte),
    .cli_rx_valid(cli_rx_valid));
  auf_host_model auf_host_model_inst (.clk(clk), .line_in(api_serial_out), .hold(hold), .send_data(send_data),
    .send(send), .grant_in_n(inbound_grant_n), .grant_n(outbound_grant_n), .line_out(api_serial_in),
    .in_request_n(inbound_request_n), .got(got), .got_data(got_data));

  ////////////////////////////////////////////////////////////////////////////
  initial forever #10 clk = ~clk;

  function automatic void step();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  endfunction : step
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic bad(input string m);
    fail_count++;
    $display("FAIL %0t %s", $time, m);
  endtask : bad
  task automatic chk(input logic [7:0] d);
    n_tests++;
    if (exp_q.size() == 0 || d !== exp_q.pop_front()) bad("byte mismatch");
  endtask : chk
  task automatic fin(input string s);
    for (int k = 0; k < 60000 && exp_q.size() != 0; k++) @(negedge clk);
    if (exp_q.size() != 0) begin
      bad("timeout");
      results();
    end
    $display("%s done", s);
  endtask : fin
  task automatic pkt(input int n);
    for (int i = 0; i < n; i++) begin
      step();
      tx_byte = '{lfsr, i == n - 1};
      tx_valid = 1'b1;
      exp_q.push_back(lfsr);
      #1;
      for (int k = 0; k < 20000 && tx_ready !== 1'b1; k++) @(negedge clk);
      if (tx_ready !== 1'b1) begin
        bad("timeout");
        results();
      end
      @(negedge clk);
    end
    tx_valid = 1'b0;
  endtask : pkt

  initial forever begin
    @(posedge got or posedge rx_valid or posedge cli_rx_valid);
    #1;
    if (got === 1'b1) chk(got_data);
    if (rx_valid === 1'b1) chk(rx_byte.data);
    if (rx_valid === 1'b1 && rx_byte.frame_err !== 1'b0) bad("inbound stop bit");
    if (cli_rx_valid === 1'b1) chk(cli_rx_byte.data);
    if (cli_rx_valid === 1'b1 && cli_rx_byte.frame_err !== 1'b0) bad("command stop bit");
  end

  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    fork
      pkt(2);
      begin
        repeat (500) @(negedge clk);
        n_tests++;
        if (outbound_request_n !== 1'b0 || api_serial_out !== 1'b1) bad("no wait for grant");
        hold = 1'b0;
        repeat (6000) @(negedge clk);
        hold = 1'b1;
        repeat (2000) @(negedge clk);
      end
    join
    hold = 1'b0;
    pkt(1);
    fin("outbound");
    step();
    send_data = lfsr;
    exp_q.push_back(lfsr);
    // No room at first: grant must wait for the node
    rx_accept_ok = 1'b0;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    repeat (20) @(negedge clk);
    n_tests++;
    if (inbound_grant_n !== 1'b1) bad("inbound grant without room");
    rx_accept_ok = 1'b1;
    repeat (2) @(negedge clk);
    n_tests++;
    if (inbound_grant_n !== 1'b0) bad("inbound grant missing");
    fin("inbound");
    step();
    cli_tx_data = lfsr;
    exp_q.push_back(lfsr);
    cli_tx_valid = 1'b1;
    @(negedge clk);
    cli_tx_valid = 1'b0;
    fin("command line");
    n_tests++;
    if (api_busy !== 1'b0) bad("port busy after transfers");
    results();
  end
endmodule : tb_auf_top
